// ==== design/asr_pkg.sv ====
// package: pin timing, cycle counts and state codes of the sram host port
`default_nettype none
package asr_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  // 55 ns grade figures; slower grade needs the larger ones
  localparam int unsigned WRITE_DATA_SETUP_NS = 25;
  localparam int unsigned WRITE_ADDRESS_SETUP_NS = 45;
  localparam int unsigned LANE_SELECT_TO_WRITE_END_NS = 45;
  localparam int unsigned ADDRESS_ACCESS_TIME_NS = 55;
  localparam int unsigned DRIVE_ENABLE_ACCESS_TIME_NS = 25;
  localparam int unsigned DESELECT_TO_STANDBY_NS = 55;
  localparam int unsigned OUTPUT_RELEASE_NS = 25;
  function automatic int unsigned ns_to_cyc_up(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int unsigned WRITE_PULSE_CYC = ns_to_cyc_up(
    (WRITE_ADDRESS_SETUP_NS > LANE_SELECT_TO_WRITE_END_NS) ?
    WRITE_ADDRESS_SETUP_NS : LANE_SELECT_TO_WRITE_END_NS);
  localparam int unsigned READ_WAIT_CYC = ns_to_cyc_up(
    (ADDRESS_ACCESS_TIME_NS > DRIVE_ENABLE_ACCESS_TIME_NS) ?
    ADDRESS_ACCESS_TIME_NS : DRIVE_ENABLE_ACCESS_TIME_NS);
  localparam int unsigned RELEASE_CYC = ns_to_cyc_up(OUTPUT_RELEASE_NS);
  localparam int unsigned CNT_W = 4;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WSET  = 3'b001,
    ST_WPULSE = 3'b010,
    ST_WEND  = 3'b011,
    ST_RWAIT = 3'b100,
    ST_RREL  = 3'b101
  } asr_state_e;
endpackage
`default_nettype wire

// ==== design/asr_cmd_if.sv ====
// interface: user request and answer between host front end and sequencer
`default_nettype none
interface asr_cmd_if;
  logic req;
  logic we;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [1:0] lanes;
  logic busy;
  logic done;
  logic [15:0] rdata;
  modport front (output req, we, addr, wdata, lanes,
                 input busy, done, rdata);
  modport seq (input req, we, addr, wdata, lanes,
               output busy, done, rdata);
endinterface
`default_nettype wire

// ==== design/asr_front.sv ====
// small module: registers a user request and holds it for the sequencer
`default_nettype none
module asr_front (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // user side
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0] lanes_i,
  // to sequencer
  asr_cmd_if.front cmd
);
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [1:0] lanes;
  } asr_front_s;
  asr_front_s s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.req = 1'b0;
    // lanes == 0 is a no-op: nothing would be moved on the pins
    if (start_i && !cmd.busy && !s_q.req && lanes_i != 2'h0) begin
      s_d.req = 1'b1;
      s_d.we = write_i;
      s_d.addr = addr_i;
      s_d.wdata = wdata_i;
      s_d.lanes = lanes_i;
    end
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign cmd.req = s_q.req;
  assign cmd.we = s_q.we;
  assign cmd.addr = s_q.addr;
  assign cmd.wdata = s_q.wdata;
  assign cmd.lanes = s_q.lanes;
endmodule
`default_nettype wire

// ==== design/asr_host.sv ====
// host controller driving an asynchronous 64k x 16 static memory
`default_nettype none
module asr_host
  import asr_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // user request
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0] lanes_i,
  // user answer
  output logic busy_o,
  output logic done_o,
  output logic [15:0] rdata_o,
  // memory pins
  output logic [15:0] mem_addr_o,
  output logic chip_select_n_o,
  output logic read_drive_n_o,
  output logic write_strobe_n_o,
  output logic low_lane_select_n_o,
  output logic high_lane_select_n_o,
  input wire logic [15:0] mem_data_i,
  output logic [15:0] mem_data_o,
  output logic [1:0] mem_data_oe_n_o
);
  // front end registers one request, taken only while the sequencer is not busy
  asr_cmd_if cmd ();
  asr_front u_front (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .start_i(start_i),
    .write_i(write_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .lanes_i(lanes_i),
    .cmd(cmd)
  );
  ////////////////////////////////////////////////////////////////////////////
  // all state in one register; every output reads straight off it
  typedef struct packed {
    asr_state_e st;
    logic [CNT_W-1:0] cnt;
    logic busy;
    logic done;
    logic [15:0] rdata;
    logic [15:0] addr;
    logic cs_n;
    logic rd_n;
    logic we_n;
    logic lo_n;
    logic hi_n;
    logic [15:0] dout;
    logic [1:0] oe_n;
    logic [1:0] lanes;
  } asr_host_s;
  asr_host_s s_q, s_d;
  // explicit cut to the counter width; all counts fit in CNT_W bits
  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    return CNT_W'(n);
  endfunction
  // merge only the lanes that were selected into the read result
  function automatic logic [15:0] merge_lanes(input logic [15:0] old_v,
                                              input logic [15:0] pin_v,
                                              input logic [1:0] ln);
    logic [15:0] r;
    r = old_v;
    if (ln[0]) r[7:0] = pin_v[7:0];
    if (ln[1]) r[15:8] = pin_v[15:8];
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.busy = (s_q.st != ST_IDLE) || cmd.req;
    // counter runs down by itself; states reload it when they wait
    if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - cyc(1);
    end
    // one transfer at a time; idle is the only state that takes work
    unique case (s_q.st)
      ST_IDLE: begin
        // everything high and released between transfers
        s_d.cs_n = 1'b1;
        s_d.rd_n = 1'b1;
        s_d.we_n = 1'b1;
        s_d.lo_n = 1'b1;
        s_d.hi_n = 1'b1;
        s_d.oe_n = 2'h3;
        if (cmd.req) begin
          // address goes out with the select in the same edge
          s_d.addr = cmd.addr;
          s_d.lanes = cmd.lanes;
          s_d.cs_n = 1'b0;
          s_d.lo_n = !cmd.lanes[0];
          s_d.hi_n = !cmd.lanes[1];
          if (cmd.we) begin
            // read drive stays high, so the memory never drives here
            s_d.dout = cmd.wdata;
            s_d.oe_n = ~cmd.lanes;
            s_d.st = ST_WSET;
          end else begin
            // selects and read drive fall together; data sampled later
            s_d.rd_n = 1'b0;
            s_d.cnt = cyc(READ_WAIT_CYC);
            s_d.st = ST_RWAIT;
          end
        end
      end
      ST_WSET: begin
        // strobe falls one cycle after address: zero setup met
        s_d.we_n = 1'b0;
        s_d.cnt = cyc(WRITE_PULSE_CYC);
        s_d.st = ST_WPULSE;
      end
      ST_WPULSE: begin
        if (s_q.cnt == cyc(1)) begin
          // strobe alone ends the write; selects and data stay a cycle
          s_d.we_n = 1'b1;
          s_d.st = ST_WEND;
        end
      end
      ST_WEND: begin
        // release after the ending edge gives hold time on data/address
        s_d.cs_n = 1'b1;
        s_d.lo_n = 1'b1;
        s_d.hi_n = 1'b1;
        s_d.oe_n = 2'h3;
        s_d.done = 1'b1;
        s_d.st = ST_IDLE;
      end
      ST_RWAIT: begin
        if (s_q.cnt == cyc(1)) begin
          // sampled after the longer of both access times
          s_d.rdata = merge_lanes(s_q.rdata, mem_data_i, s_q.lanes);
          s_d.rd_n = 1'b1;
          s_d.cs_n = 1'b1;
          s_d.lo_n = 1'b1;
          s_d.hi_n = 1'b1;
          s_d.cnt = cyc(RELEASE_CYC);
          s_d.st = ST_RREL;
        end
      end
      ST_RREL: begin
        // memory needs time to release before the next write may drive
        if (s_q.cnt == cyc(1)) begin
          s_d.done = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        // only reachable after an upset of the state bits
        s_d.st = ST_IDLE;
      end
    endcase
  end
  // reset parks every strobe and select high, address and data at zero, both data lanes released
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q <= '{
        st: ST_IDLE,
        cnt: '0,
        busy: 1'b0,
        done: 1'b0,
        rdata: 16'h0000,
        addr: 16'h0000,
        cs_n: 1'b1,
        rd_n: 1'b1,
        we_n: 1'b1,
        lo_n: 1'b1,
        hi_n: 1'b1,
        dout: 16'h0000,
        oe_n: 2'h3,
        lanes: 2'h0
      };
    end else begin
      s_q <= s_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // back to the front end
  assign cmd.busy = s_q.busy;
  assign cmd.done = s_q.done;
  assign cmd.rdata = s_q.rdata;
  // user answer
  assign busy_o = s_q.busy;
  assign done_o = s_q.done;
  assign rdata_o = s_q.rdata;
  // memory pins
  assign mem_addr_o = s_q.addr;
  assign chip_select_n_o = s_q.cs_n;
  assign read_drive_n_o = s_q.rd_n;
  assign write_strobe_n_o = s_q.we_n;
  assign low_lane_select_n_o = s_q.lo_n;
  assign high_lane_select_n_o = s_q.hi_n;
  assign mem_data_o = s_q.dout;
  assign mem_data_oe_n_o = s_q.oe_n;
endmodule
`default_nettype wire

// ==== dv/asr_sram_model.sv ====
// model: behavioural 64k x 16 static memory on the host port pins
`default_nettype none
module asr_sram_model (
  // pins from host
  input wire logic [15:0] addr_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic we_n_i,
  input wire logic lo_n_i,
  input wire logic hi_n_i,
  input wire logic [15:0] host_data_i,
  input wire logic [1:0] host_oe_n_i,
  // resolved data wire
  output logic [15:0] bus_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [0:65535];
  logic [15:0] word;
  logic rd_act;
  assign word = mem[addr_i];
  // released lanes show the inverse word so no stale value can pass
  assign rd_act = !cs_n_i && !rd_n_i && we_n_i;
  assign bus_o[7:0] = !host_oe_n_i[0] ? host_data_i[7:0] :
    (rd_act && !lo_n_i) ? word[7:0] : ~word[7:0];
  assign bus_o[15:8] = !host_oe_n_i[1] ? host_data_i[15:8] :
    (rd_act && !hi_n_i) ? word[15:8] : ~word[15:8];
  // store on the strobe edge; selects rising later change nothing
  always @(posedge we_n_i) begin
    if (!cs_n_i && !lo_n_i)
      mem[addr_i][7:0] <= bus_o[7:0];
    if (!cs_n_i && !hi_n_i)
      mem[addr_i][15:8] <= bus_o[15:8];
  end
endmodule
`default_nettype wire

// ==== dv/asr_host_chk.sv ====
// checker: pin timing relations of the sram host port
`default_nettype none
module asr_host_chk (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // memory pins
  input wire logic [15:0] mem_addr_o,
  input wire logic chip_select_n_o,
  input wire logic read_drive_n_o,
  input wire logic write_strobe_n_o,
  input wire logic low_lane_select_n_o,
  input wire logic high_lane_select_n_o,
  input wire logic [15:0] mem_data_o,
  input wire logic [1:0] mem_data_oe_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_pulse;
    !write_strobe_n_o [*2] ##1 write_strobe_n_o;
  endsequence
  sequence s_rd_wait;
    (!read_drive_n_o && write_strobe_n_o) [*2] ##1 read_drive_n_o;
  endsequence
  property p_win_sel;
    !write_strobe_n_o |-> !chip_select_n_o;
  endproperty
  a_win_sel: assert property (p_win_sel) else $error("strobe unselected");
  property p_pulse;
    $fell(write_strobe_n_o) |-> s_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse short");
  property p_data;
    !write_strobe_n_o |-> $stable(mem_data_o) && mem_data_oe_n_o != 2'b11;
  endproperty
  a_data: assert property (p_data) else $error("write data moved");
  property p_addr;
    !chip_select_n_o && !$fell(chip_select_n_o) |-> $stable(mem_addr_o);
  endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_lanes;
    !write_strobe_n_o |->
      {high_lane_select_n_o, low_lane_select_n_o} == mem_data_oe_n_o;
  endproperty
  a_lanes: assert property (p_lanes) else $error("lane mismatch");
  property p_end;
    $rose(write_strobe_n_o) |-> !chip_select_n_o ##1
      (chip_select_n_o && mem_data_oe_n_o == 2'b11);
  endproperty
  a_end: assert property (p_end) else $error("write end order");
  property p_rd_oe;
    !read_drive_n_o |-> mem_data_oe_n_o == 2'b11 && !chip_select_n_o;
  endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("drive in read");
  property p_rd_wait;
    $fell(read_drive_n_o) |-> s_rd_wait;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read strobe");
endmodule
`default_nettype wire

// ==== dv/asr_host_test.sv ====
// testbench: lane writes, reads, refusal and reset against the model
`default_nettype none
module asr_host_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic w;
    logic [15:0] a;
    logic [15:0] d;
    logic [1:0] l;
    logic [15:0] e;
  } asr_row_s;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic start_i = 1'b0;
  asr_row_s cur = '0;
  logic busy_o, done_o, cs_n, rd_n, we_n, lo_n, hi_n;
  logic [15:0] rdata_o, mem_addr_o, mem_data_o, bus;
  logic [1:0] oe_n;
  int miscompares = 0;
  int checked = 0;
  int n;
  int exp_n;
  asr_row_s rows [8] = '{
    '{1'b1, 16'h0001, 16'h1234, 2'h3, 16'h0000},
    '{1'b1, 16'hffff, 16'habcd, 2'h3, 16'h0000},
    '{1'b1, 16'h0001, 16'h55aa, 2'h1, 16'h0000},
    '{1'b1, 16'hffff, 16'h9988, 2'h2, 16'h0000},
    '{1'b0, 16'h0001, 16'h0000, 2'h3, 16'h12aa},
    '{1'b0, 16'hffff, 16'h0000, 2'h3, 16'h99cd},
    '{1'b0, 16'h0001, 16'h0000, 2'h1, 16'h99aa},
    '{1'b0, 16'h0001, 16'h0000, 2'h2, 16'h12aa}};
  always #20 core_clk_i = ~core_clk_i;
  asr_host asr_host_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .start_i(start_i), .write_i(cur.w), .addr_i(cur.a), .wdata_i(cur.d),
    .lanes_i(cur.l), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o),
    .mem_addr_o(mem_addr_o), .chip_select_n_o(cs_n),
    .read_drive_n_o(rd_n), .write_strobe_n_o(we_n),
    .low_lane_select_n_o(lo_n), .high_lane_select_n_o(hi_n),
    .mem_data_i(bus), .mem_data_o(mem_data_o), .mem_data_oe_n_o(oe_n));
  asr_sram_model asr_sram_model_inst (.addr_i(mem_addr_o), .cs_n_i(cs_n),
    .rd_n_i(rd_n), .we_n_i(we_n), .lo_n_i(lo_n), .hi_n_i(hi_n),
    .host_data_i(mem_data_o), .host_oe_n_i(oe_n), .bus_o(bus));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one request, then count edges to done; a spare cycle keeps busy clear
  task automatic xfer(input asr_row_s r);
    cur = r;
    start_i = 1'b1;
    @(posedge core_clk_i);
    #1;
    start_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 20) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    @(posedge core_clk_i);
    #1;
  endtask
  initial begin
    repeat (6) @(posedge core_clk_i);
    #1;
    check({13'h0, cs_n, oe_n}, 16'h0007);
    reset_i = 1'b0;
    foreach (rows[i]) begin
      xfer(rows[i]);
      // write: front, setup, pulse, end; read: front, wait, release
      exp_n = rows[i].w ? 3 + asr_pkg::WRITE_PULSE_CYC :
        1 + asr_pkg::READ_WAIT_CYC + asr_pkg::RELEASE_CYC;
      check(16'(n), 16'(exp_n));
      if (rows[i].w === 1'b0)
        check(rdata_o, rows[i].e);
    end
    xfer('{1'b1, 16'h0001, 16'h0000, 2'h0, 16'h0000});
    check({busy_o, cs_n, 14'(n)}, 16'h4014);
    cur = '{1'b1, 16'h0001, 16'h0f0f, 2'h3, 16'h0000};
    start_i = 1'b1;
    // reset lands with selects low but before the strobe: nothing stored
    repeat (2) @(posedge core_clk_i);
    #1;
    start_i = 1'b0;
    reset_i = 1'b1;
    #1;
    check({13'h0, cs_n, oe_n}, 16'h0007);
    @(posedge core_clk_i);
    #1;
    reset_i = 1'b0;
    xfer('{1'b0, 16'h0001, 16'h0000, 2'h3, 16'h0000});
    check(rdata_o, 16'h12aa);
    test_done;
  end
  initial begin
    #100000;
    miscompares++;
    test_done;
  end
endmodule
bind asr_host asr_host_chk asr_host_chk_inst (.core_clk_i(core_clk_i),
  .reset_i(reset_i), .mem_addr_o(mem_addr_o),
  .chip_select_n_o(chip_select_n_o), .read_drive_n_o(read_drive_n_o),
  .write_strobe_n_o(write_strobe_n_o),
  .low_lane_select_n_o(low_lane_select_n_o),
  .high_lane_select_n_o(high_lane_select_n_o),
  .mem_data_o(mem_data_o), .mem_data_oe_n_o(mem_data_oe_n_o));
`default_nettype wire
